//--- rtl/buck_seq_ocp_ctrl.sv
// Sequencing, shutdown and overcurrent control for a buck power stage.
// Assumes comparator inputs are asynchronous and the current value is on mclk.
`timescale 1ns/100ps
`include "buck_ctrl_params.svh"

module buck_seq_ocp_ctrl #(
  parameter int MS_CYC = `MS_CYCLES
) (
  // Clock and reset
  input  wire logic                     mclk,
  input  wire logic                     reset_n,
  // Register port
  input  wire logic [7:0]               regAddr,
  input  wire logic [15:0]              regWrData,
  input  wire logic                     regWr,
  input  wire logic                     regRd,
  output logic      [15:0]              regRdData,
  // Analog side inputs
  input  wire logic                     enablePin,
  input  wire logic                     busUvOk,
  input  wire logic                     ocTrip,
  input  wire logic                     ovTrip,
  input  wire logic                     dutyBelowEighth,
  input  wire logic                     cfgLoaded,
  input  wire logic [11:0]              iAvg,
  // Power stage outputs
  output logic                          convEnable,
  output logic                          hsGateEn,
  output logic                          lsGateEn,
  output logic                          setPulse,
  output buck_ctrl_pkg::duty_cap_t      dutyCap,
  output logic      [11:0]              refLevel,
  output logic                          ocWarn,
  output logic                          alertOut_n
);
  import buck_ctrl_pkg::*;

  // Two-flop synchronisers for pin-side levels
  logic [4:0] syncA;
  logic [4:0] syncB;
  always_ff @(posedge mclk) begin
    syncA <= {dutyBelowEighth, ovTrip, ocTrip, busUvOk, enablePin};
    syncB <= syncA;
  end
  wire logic pinEn   = syncB[0];
  wire logic busOk   = syncB[1];
  wire logic ocS     = syncB[2];
  wire logic ovS     = syncB[3];
  wire logic dutyLow = syncB[4];

  // Software registers
  logic [15:0] ctrl;
  logic [6:0]  tonDelay;
  logic [6:0]  tonRise;
  logic [6:0]  toffDelay;
  logic [6:0]  toffFall;
  logic [10:0] freqKhz;
  logic [11:0] refTarget;
  logic [11:0] warnLimit;
  logic        ocFault;
  logic        ovFault;
  seq_state_t  state;
  seq_state_t  next_state;

  wire logic       wrHit   = regWr;
  wire logic [10:0] wrFreq = regWrData[10:0];
  wire logic [10:0] freqClamped = (wrFreq < 11'(`FREQ_MIN_KHZ)) ? 11'(`FREQ_MIN_KHZ) :
                                  (wrFreq > 11'(`FREQ_MAX_KHZ)) ? 11'(`FREQ_MAX_KHZ) : wrFreq;
  wire logic clearWr = wrHit && regAddr == `REG_CLEAR;

  // Register writes; out-of-range frequencies clamp rather than fault
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ctrl      <= `CTRL_RST;
      tonDelay  <= 7'h00;
      tonRise   <= `RISE_RST;
      toffDelay <= 7'h00;
      toffFall  <= `RISE_RST;
      freqKhz   <= `FREQ_RST;
      refTarget <= `REF_RST;
      warnLimit <= `WARN_RST;
    end else if (wrHit) begin
      case (regAddr)
        `REG_CTRL:       ctrl      <= regWrData;
        `REG_TON_DELAY:  tonDelay  <= regWrData[6:0];
        `REG_TON_RISE:   tonRise   <= regWrData[6:0];
        `REG_TOFF_DELAY: toffDelay <= regWrData[6:0];
        `REG_TOFF_FALL:  toffFall  <= regWrData[6:0];
        `REG_FREQ:       freqKhz   <= freqClamped; // RL7
        `REG_REF:        refTarget <= regWrData[11:0];
        `REG_OC_WARN:    warnLimit <= regWrData[11:0];
        default:         ;
      endcase
    end
  end

  // Control field decode
  wire logic     swEn     = ctrl[`CTRL_SW_EN];
  wire en_mode_t enMode   = en_mode_t'(ctrl[`CTRL_MODE_HI:`CTRL_MODE_LO]);
  wire logic     softStop = ctrl[`CTRL_SOFT];
  wire logic     pin_programmed_voltage_mode     = ctrl[`CTRL_PIN_PROGRAMMED_VOLTAGE_MODE];
  wire logic     latchRsp = ctrl[`CTRL_LATCH];
  wire logic     ccMode   = ctrl[`CTRL_CC];

  // Enable combination: the pin drop is immediate, a software drop may soft stop
  wire logic hwOk = (enMode == EN_SW) || pinEn;   // RL2
  wire logic swOk = (enMode == EN_HW) || swEn;    // RL2 RL9
  wire logic preOk = cfgLoaded && busOk;
  wire logic enOk = preOk && hwOk && swOk;        // RL1
  wire logic hardOff = !preOk || !hwOk || ovS;    // RL8 RL6
  wire logic softOff = !swOk && softStop;         // RL9

  // Millisecond and microsecond timebase
  logic [$clog2(MS_CYC)-1:0] msDiv;
  logic [7:0]                 msCnt;
  logic [3:0]                 usDiv;
  wire logic msTick = msDiv == ($clog2(MS_CYC))'(MS_CYC - 1);
  wire logic usTick = usDiv == 4'(`US_CYCLES - 1);
  wire logic stateChg = next_state != state;
  always_ff @(posedge mclk) begin
    if (!reset_n || !convEnable && state != S_HICCUP) begin
      msDiv <= '0;   // RL24
      usDiv <= 4'h0;
      msCnt <= 8'h00;
    end else begin
      // Restart the divider on every state change so each timed state gets whole milliseconds
      msDiv <= (msTick || stateChg) ? '0 : msDiv + 1'b1;
      usDiv <= usTick ? 4'h0 : usDiv + 4'h1;
      msCnt <= stateChg ? 8'h00 : (msTick ? msCnt + 8'h01 : msCnt);
    end
  end

  // Reference ramp: Bresenham spreads refTarget steps across the ramp time in host mode; pin-programmed mode steps on usTick
  wire logic [6:0]  rampMs  = (state == S_FALL) ? toffFall : tonRise;
  wire logic [6:0]  rampMsC = (rampMs == 7'h00) ? 7'h01 : rampMs;
  wire logic [20:0] rampDen = 21'(rampMsC) * 21'(MS_CYC);
  logic [20:0] acc;
  wire logic [20:0] accSum = acc + 21'(refTarget);
  wire logic accStep = accSum >= rampDen;
  wire logic rampStep = pin_programmed_voltage_mode ? usTick : accStep;   // RL5 RL12
  wire logic riseDone = refLevel >= refTarget;
  wire logic fallDone = refLevel == 12'h000;

  // Overcurrent bookkeeping
  logic [3:0] ocTotal;
  logic [1:0] ocRun;
  logic [2:0] okRun;
  logic       cycleEnd;
  logic       ocSeen;
  wire logic ocLimit = cycleEnd && ocSeen && ocTotal == 4'(`OC_MAX_CYCLES - 1);

  // Sequencer next state
  always_comb begin
    next_state = state;
    unique case (state)
      S_OFF:     if (enOk) next_state = pin_programmed_voltage_mode ? S_RISE : S_TON_DLY;               // RL1
      S_TON_DLY: if (hardOff || !swOk) next_state = S_OFF;
                 else if (msCnt >= 8'(tonDelay)) next_state = S_RISE;            // RL3
      S_RISE:    if (hardOff || !swOk) next_state = S_OFF;
                 else if (ocLimit) next_state = latchRsp ? S_LATCHED : S_HICCUP; // RL6
                 else if (riseDone) next_state = S_ON;                          // RL4
      S_ON:      if (hardOff) next_state = S_OFF;                               // RL8
                 else if (ocLimit) next_state = latchRsp ? S_LATCHED : S_HICCUP; // RL19
                 else if (softOff) next_state = pin_programmed_voltage_mode ? S_FALL : S_TOFF;         // RL9
                 else if (!swOk) next_state = S_OFF;
      S_TOFF:    if (hardOff || ocLimit) next_state = S_OFF;
                 else if (msCnt >= 8'(toffDelay)) next_state = S_FALL;          // RL10
      S_FALL:    if (hardOff || ocLimit || fallDone) next_state = S_OFF;        // RL11
      S_HICCUP:  if (msTick && msCnt == 8'(`HICCUP_MS - 1)) next_state = S_OFF; // RL17 RL18
      S_LATCHED: if (!hwOk || !swOk) next_state = S_OFF;
    endcase
  end

  // Sequencer, reference and gate drive registers
  wire logic next_conv = !(next_state inside {S_OFF, S_HICCUP, S_LATCHED});
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state      <= S_OFF;
      convEnable <= 1'b0;
      hsGateEn   <= 1'b0;
      lsGateEn   <= 1'b0;
      refLevel   <= 12'h000;
      acc        <= 21'h0;
    end else begin
      state      <= next_state;
      convEnable <= next_conv;
      hsGateEn   <= next_conv;   // RL8
      lsGateEn   <= next_conv;
      if (!next_conv) begin
        refLevel <= 12'h000;
        acc      <= 21'h0;
      end else if (state == S_RISE && !riseDone) begin
        acc      <= accStep ? accSum - rampDen : accSum;
        refLevel <= rampStep ? refLevel + 12'h001 : refLevel;   // RL4 RL5
      end else if (state == S_FALL && !fallDone) begin
        acc      <= accStep ? accSum - rampDen : accSum;
        refLevel <= rampStep ? refLevel - 12'h001 : refLevel;   // RL11 RL12
      end else begin
        acc      <= 21'h0;
      end
    end
  end

  // Switching period from the frequency setting; low clock rate limits resolution
  wire logic [13:0] period  = 14'(`CLK_KHZ) / 14'(freqKhz);
  wire logic [13:0] setLen  = (period[13:3] == 11'h0) ? 14'h1 : {3'b000, period[13:3]};
  logic [13:0] phase;
  wire logic lastPhase = phase >= period - 14'h1;
  wire logic sampleWin = phase < 14'(`OC_SAMPLE_CYC);
  always_ff @(posedge mclk) begin
    if (!reset_n || !convEnable) begin
      phase    <= 14'h0;
      setPulse <= 1'b0;
      cycleEnd <= 1'b0;
      ocSeen   <= 1'b0;
    end else begin
      phase    <= lastPhase ? 14'h0 : phase + 14'h1;
      setPulse <= lastPhase || (phase + 14'h1 < setLen);   // RL16
      cycleEnd <= lastPhase;
      // The sample window shares its cycle with cycleEnd, so a fresh sample must survive it
      ocSeen   <= (ocSeen && !cycleEnd) || (sampleWin && ocS);   // RL16
    end
  end

  // Overcurrent counting and duty-cap foldback
  wire logic runFull = ocRun == 2'(`OC_STEP_RUN - 1);
  wire logic okFull  = okRun == 3'(`OK_STEP_RUN - 1);
  always_ff @(posedge mclk) begin
    if (!reset_n || !convEnable) begin
      ocTotal <= 4'h0;   // RL18
      ocRun   <= 2'h0;
      okRun   <= 3'h0;
      dutyCap <= CAP_NOM;
    end else if (cycleEnd && ocSeen) begin
      ocTotal <= ocTotal + 4'h1;   // RL17 RL20
      okRun   <= 3'h0;
      ocRun   <= runFull ? 2'h0 : ocRun + 2'h1;
      if (runFull && ccMode && !dutyLow && dutyCap != CAP_EIGHTH) begin
        dutyCap <= duty_cap_t'(dutyCap + 2'h1);   // RL21
      end
    end else if (cycleEnd) begin
      ocRun <= 2'h0;
      okRun <= okFull ? 3'h0 : okRun + 3'h1;
      if (okFull && dutyCap != CAP_NOM) begin
        dutyCap <= duty_cap_t'(dutyCap - 2'h1);   // RL22
      end
      if (okFull && dutyCap == CAP_NOM) ocTotal <= 4'h0;
    end
  end

  // Fault status: a new event wins over a clear in the same cycle
  wire logic warnHit = iAvg > warnLimit;   // RL15
  wire logic ocEvt = ocLimit;
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ocFault    <= 1'b0;
      ovFault    <= 1'b0;
      ocWarn     <= 1'b0;
      alertOut_n <= 1'b1;
    end else begin
      ocFault    <= ocEvt || (ocFault && !clearWr);   // RL23
      ovFault    <= ovS || (ovFault && !clearWr);
      ocWarn     <= warnHit || (ocWarn && !clearWr);
      alertOut_n <= !(ocEvt || ovS || warnHit || ((ocFault || ovFault || ocWarn) && !clearWr));
    end
  end

  // Read decode; data stands in the cycle after the strobe
  wire logic [7:0] iQuarter = (iAvg[11:10] != 2'b00) ? 8'hff : iAvg[9:2];   // RL14
  logic [15:0] rdMux;
  always_comb begin
    unique case (regAddr)
      `REG_CTRL:       rdMux = ctrl;
      `REG_TON_DELAY:  rdMux = {9'h0, tonDelay};
      `REG_TON_RISE:   rdMux = {9'h0, tonRise};
      `REG_TOFF_DELAY: rdMux = {9'h0, toffDelay};
      `REG_TOFF_FALL:  rdMux = {9'h0, toffFall};
      `REG_FREQ:       rdMux = {5'h0, freqKhz};
      `REG_REF:        rdMux = {4'h0, refTarget};
      `REG_OC_WARN:    rdMux = {4'h0, warnLimit};
      `REG_IOUT:       rdMux = {4'h0, iAvg};   // RL13
      `REG_IOUT_QA:    rdMux = {8'h0, iQuarter};
      `REG_STATUS:     rdMux = {4'h0, ocTotal, 1'b0, ocWarn, ovFault, ocFault,
                                dutyCap, state[1:0]} | {state[2], 15'h0};
      default:         rdMux = 16'h0000;
    endcase
  end
  always_ff @(posedge mclk) begin
    if (!reset_n) regRdData <= 16'h0000;
    else regRdData <= regRd ? rdMux : 16'h0000;
  end

  // Checks
  property p_start_gate;
    @(posedge mclk) disable iff (!reset_n)
    (state == S_OFF && next_state != S_OFF) |-> enOk;
  endproperty
  a_start_gate: assert property (p_start_gate) else $error("start without enables"); // RL1
  property p_pin_off;
    @(posedge mclk) disable iff (!reset_n)
    (state == S_ON && !hwOk) |=> (!hsGateEn && !lsGateEn);
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("drivers left on"); // RL8
  property p_hiccup_entry;
    @(posedge mclk) disable iff (!reset_n)
    (ocLimit && !latchRsp && state inside {S_RISE, S_ON} && !hardOff) |=> ##1 !convEnable;
  endproperty
  a_hiccup_entry: assert property (p_hiccup_entry) else $error("no hiccup"); // RL17
  property p_latch;
    @(posedge mclk) disable iff (!reset_n)
    (ocLimit && latchRsp && state == S_ON && !hardOff) |=> state == S_LATCHED;
  endproperty
  a_latch: assert property (p_latch) else $error("no latched stop"); // RL19
  property p_hiccup_end;
    @(posedge mclk) disable iff (!reset_n)
    (state == S_HICCUP && next_state == S_OFF) |-> (msCnt == 8'(`HICCUP_MS - 1) && msTick);
  endproperty
  a_hiccup_end: assert property (p_hiccup_end) else $error("hiccup length"); // RL18
  property p_low_duty;
    @(posedge mclk) disable iff (!reset_n)
    (cycleEnd && ocSeen && dutyLow && convEnable) |=> dutyCap == $past(dutyCap);
  endproperty
  a_low_duty: assert property (p_low_duty) else $error("cap moved at low duty"); // RL20
  property p_fold;
    @(posedge mclk) disable iff (!reset_n)
    (cycleEnd && ocSeen && runFull && ccMode && !dutyLow && dutyCap != CAP_EIGHTH
     && convEnable) |=> dutyCap == duty_cap_t'($past(dutyCap) + 2'h1);
  endproperty
  a_fold: assert property (p_fold) else $error("foldback step missing"); // RL21
  property p_recover;
    @(posedge mclk) disable iff (!reset_n)
    (cycleEnd && !ocSeen && okFull && dutyCap != CAP_NOM && convEnable)
    |=> dutyCap == duty_cap_t'($past(dutyCap) - 2'h1);
  endproperty
  a_recover: assert property (p_recover) else $error("recovery step missing"); // RL22
  property p_quarter;
    @(posedge mclk) disable iff (!reset_n)
    (regRd && regAddr == `REG_IOUT_QA && iAvg[11:10] == 2'b00)
    |=> regRdData[7:0] == $past(iAvg[9:2]);
  endproperty
  a_quarter: assert property (p_quarter) else $error("quarter amp read"); // RL14
  c_hiccup: cover property (@(posedge mclk) disable iff (!reset_n) state == S_HICCUP);
  c_latched: cover property (@(posedge mclk) disable iff (!reset_n) state == S_LATCHED);
  c_ramp: cover property (@(posedge mclk) disable iff (!reset_n) state == S_RISE ##1 state == S_ON);
  c_eighth: cover property (@(posedge mclk) disable iff (!reset_n) dutyCap == CAP_EIGHTH);
endmodule

//--- rtl/buck_ctrl_params.svh
// Constants for the buck sequencing and overcurrent controller.
// Assumes a 10 MHz mclk; included by the controller and its testbench.
//
// Functional notes
// [RL1] Reference ramp starts only with enable pin, bus UVLO ok and config loaded.
// [RL2] Software enable replaces or joins the hardware enable pin, as configured.
// [RL3] Host mode: turn-on delay 0 to 127 ms in 1 ms steps.
// [RL4] Host mode: reference rise time 1 to 127 ms in 1 ms steps.
// [RL5] Pin-programmed mode: reference rises at fixed 0.625 mV per microsecond.
// [RL6] Overcurrent and overvoltage protection stay armed during the startup ramp.
// [RL7] Switching frequency programmable from 150 kHz to 1.5 MHz.
// [RL8] By default enable pin low turns both drivers off at once.
// [RL9] Host may turn conversion off by command in both modes, optional soft stop.
// [RL10] Host mode soft stop: turn-off delay 0 to 127 ms in 1 ms steps.
// [RL11] Host mode soft stop: ramp-down time 1 to 127 ms in 1 ms steps.
// [RL12] Pin-programmed mode soft stop ramps down at 0.625 mV per microsecond.
// [RL13] Average output current readable with 1/16 A resolution.
// [RL14] Output current also readable as 8-bit value at 1/4 A per count.
// [RL15] Overcurrent warning compares digitized current with a limit; faults ignore it.
// [RL16] Set pulse is 12.5% of period; sample overcurrent after its rising edge.
// [RL17] Default: 8 total overcurrent cycles enter 20 ms hiccup, enable held low.
// [RL18] After hiccup clear overcurrent state and restart, repeating while overload lasts.
// [RL19] Response after 8 limited cycles: latched shutdown or hiccup, hiccup default.
// [RL20] Overcurrent at duty below 0.125 only counts, no duty reduction.
// [RL21] Constant current: 3 consecutive overcurrent cycles step the duty cap down.
// [RL22] 4 consecutive clean cycles double the duty cap back toward nominal.
// [RL23] Host should clear faults after startup to release the alert output.
// [RL24] Delay, ramp and hiccup timers use the timebase and idle when disabled.
`ifndef BUCK_CTRL_PARAMS_SVH
`define BUCK_CTRL_PARAMS_SVH

// Timebase
`define CLK_KHZ        10000
`define CLK_PERIOD_NS  100
`define MS_CYCLES      (`CLK_KHZ)
`define SLEW_US        1
`define US_CYCLES      ((`SLEW_US * 1000) / `CLK_PERIOD_NS)
`define OC_SAMPLE_NS   75
`define OC_SAMPLE_CYC  ((`OC_SAMPLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HICCUP_MS      20
`define OC_MAX_CYCLES  8
`define OC_STEP_RUN    3
`define OK_STEP_RUN    4
`define FREQ_MIN_KHZ   150
`define FREQ_MAX_KHZ   1500

// Register offsets
`define REG_CTRL       8'h00
`define REG_TON_DELAY  8'h01
`define REG_TON_RISE   8'h02
`define REG_TOFF_DELAY 8'h03
`define REG_TOFF_FALL  8'h04
`define REG_FREQ       8'h05
`define REG_REF        8'h06
`define REG_OC_WARN    8'h07
`define REG_IOUT       8'h08
`define REG_IOUT_QA    8'h09
`define REG_STATUS     8'h0a
`define REG_CLEAR      8'h0b

// CTRL fields
`define CTRL_SW_EN     0
`define CTRL_MODE_LO   1
`define CTRL_MODE_HI   2
`define CTRL_SOFT      3
`define CTRL_PIN_PROGRAMMED_VOLTAGE_MODE      4
`define CTRL_LATCH     5
`define CTRL_CC        6

// Reset values
`define CTRL_RST       16'h0000
`define RISE_RST       7'h01
`define FREQ_RST       11'h190
`define REF_RST        12'h000
`define WARN_RST       12'hfff

`endif

//--- rtl/buck_ctrl_pkg.sv
// Types shared by the buck sequencing controller and its environment.
// Assumes nothing beyond the parameter header.
package buck_ctrl_pkg;
  typedef enum logic [2:0] {
    S_OFF     = 3'b000,
    S_TON_DLY = 3'b001,
    S_RISE    = 3'b010,
    S_ON      = 3'b011,
    S_TOFF    = 3'b100,
    S_FALL    = 3'b101,
    S_HICCUP  = 3'b110,
    S_LATCHED = 3'b111
  } seq_state_t;

  typedef enum logic [1:0] {
    CAP_NOM    = 2'b00,
    CAP_HALF   = 2'b01,
    CAP_QUART  = 2'b10,
    CAP_EIGHTH = 2'b11
  } duty_cap_t;

  typedef enum logic [1:0] {
    EN_HW   = 2'b00,
    EN_SW   = 2'b01,
    EN_BOTH = 2'b10
  } en_mode_t;
endpackage

//--- sim/power_stage_model.sv
// Behavioural power stage beside the buck controller: turns a load request into trips.
// Assumes the bench drives overload on mclk and that current flows only while switching.
`timescale 1ns/100ps

module power_stage_model (
  // Clock
  input  wire logic mclk,
  // Gate drive from the controller
  input  wire logic hsGateEn,
  input  wire logic lsGateEn,
  // Load condition from the bench
  input  wire logic overload,
  // Valley comparator output
  output logic      ocTrip
);
  // No switching means no valley current, so an idle stage never trips
  always_ff @(posedge mclk) begin
    ocTrip <= overload & hsGateEn & lsGateEn;
  end
endmodule

//--- sim/buck_seq_ocp_ctrl_tb.sv
// Self-checking bench for the buck sequencing and overcurrent controller.
// Assumes a 10 MHz mclk, a 16-cycle millisecond and a 1500 kHz (6-cycle) switching period.
`timescale 1ns/100ps
`include "buck_ctrl_params.svh"

module buck_seq_ocp_ctrl_tb;
  import buck_ctrl_pkg::*;
  localparam int MS  = 16;
  localparam int PER = 6;
  logic        mclk = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  regAddr = 8'h00;
  logic [15:0] regWrData = 16'h0000;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic [15:0] regRdData;
  logic        enablePin = 1'b0;
  logic        busUvOk = 1'b0;
  logic        ovTrip = 1'b0;
  logic        dutyBelowEighth = 1'b0;
  logic        cfgLoaded = 1'b0;
  logic        overload = 1'b0;
  logic [11:0] iAvg = 12'h000;
  logic        ocTrip, convEnable, hsGateEn, lsGateEn, setPulse, ocWarn, alertOut_n;
  logic [11:0] refLevel;
  duty_cap_t   dutyCap;
  logic [15:0] expQ[$];
  logic        rdPrev = 1'b0;
  logic [15:0] seed = 16'h0016;
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          cycles = 0;
  int          n;

  always #50 mclk = ~mclk;

  buck_seq_ocp_ctrl #(.MS_CYC(MS)) u_dut (.mclk(mclk), .reset_n(reset_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .enablePin(enablePin), .busUvOk(busUvOk), .ocTrip(ocTrip), .ovTrip(ovTrip),
    .dutyBelowEighth(dutyBelowEighth), .cfgLoaded(cfgLoaded), .iAvg(iAvg),
    .convEnable(convEnable), .hsGateEn(hsGateEn), .lsGateEn(lsGateEn), .setPulse(setPulse),
    .dutyCap(dutyCap), .refLevel(refLevel), .ocWarn(ocWarn), .alertOut_n(alertOut_n));

  power_stage_model u_stage (.mclk(mclk), .hsGateEn(hsGateEn), .lsGateEn(lsGateEn),
    .overload(overload), .ocTrip(ocTrip));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Bus tasks start after an edge, so back-to-back calls never drive a strobe twice at once
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge mclk);
    regRd <= 1'b1;
    regAddr <= a;
    expQ.push_back(e);
    @(posedge mclk);
    regRd <= 1'b0;
  endtask

  task automatic waitConv(input logic v, input int maxc, output int cnt);
    cnt = 0;
    while (convEnable !== v && cnt < maxc) begin
      @(negedge mclk);
      cnt++;
    end
    check("convEnable", {15'h0000, convEnable}, {15'h0000, v});
  endtask

  task automatic waitCap(input duty_cap_t c, input int maxc, output int cnt);
    cnt = 0;
    while (dutyCap !== c && cnt < maxc) begin
      @(negedge mclk);
      cnt++;
    end
    check("dutyCap", {14'h0000, dutyCap}, {14'h0000, c});
  endtask

  // Read data stands only in the cycle after the strobe, so it is judged mid-cycle
  always @(posedge mclk) begin
    rdPrev <= regRd;
    cycles <= cycles + 1;
  end

  always @(negedge mclk) begin
    if (rdPrev && expQ.size() > 0)
      check("regRdData", regRdData, expQ.pop_front());
    if (cycles > 20000) begin
      n_mismatch++;
      stop_test();
    end
  end

  // Main sequence
  initial begin
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    $display("Test registers");
    rd(`REG_CTRL, `CTRL_RST);
    rd(`REG_TON_RISE, {9'h000, `RISE_RST});
    rd(`REG_OC_WARN, {4'h0, `WARN_RST});
    rd(`REG_FREQ, {5'h00, `FREQ_RST});
    rd(8'h20, 16'h0000);
    wr(`REG_FREQ, 16'h000a);
    rd(`REG_FREQ, 16'h0096);
    wr(`REG_FREQ, 16'h07d0);
    rd(`REG_FREQ, 16'h05dc);
    $display("Test telemetry");
    wr(`REG_OC_WARN, 16'h0100);
    iAvg <= 12'h080;
    repeat (4) @(negedge mclk);
    check("ocWarn low", {15'h0000, ocWarn}, 16'h0000);
    iAvg <= 12'h300;
    repeat (4) @(negedge mclk);
    check("ocWarn high", {15'h0000, ocWarn}, 16'h0001);
    for (int i = 0; i < 5; i++) begin
      seed = lfsr(seed);
      iAvg <= (i == 4) ? 12'hfff : seed[11:0];
      @(negedge mclk);
      rd(`REG_IOUT, {4'h0, iAvg});
      rd(`REG_IOUT_QA, (iAvg[11:2] > 10'h0ff) ? 16'h00ff : {6'h00, iAvg[11:2]});
    end
    iAvg <= 12'h000;
    repeat (2) @(negedge mclk);
    check("idle read data", regRdData, 16'h0000);
    $display("Test startup");
    wr(`REG_TON_DELAY, 16'h0002);
    wr(`REG_TON_RISE, 16'h0002);
    wr(`REG_REF, 16'h0010);
    enablePin <= 1'b1;
    cfgLoaded <= 1'b1;
    repeat (10) @(negedge mclk);
    check("off without bus", {15'h0000, convEnable}, 16'h0000);
    cfgLoaded <= 1'b0;
    busUvOk <= 1'b1;
    repeat (10) @(negedge mclk);
    check("off without config", {15'h0000, convEnable}, 16'h0000);
    cfgLoaded <= 1'b1;
    waitConv(1'b1, 8, n);
    repeat (2 * MS - 4) @(negedge mclk);
    check("refLevel in delay", {4'h0, refLevel}, 16'h0000);
    repeat (2 * MS + 10) @(negedge mclk);
    check("refLevel at target", {4'h0, refLevel}, 16'h0010);
    enablePin <= 1'b0;
    waitConv(1'b0, 4, n);
    check("gates off", {14'h0000, hsGateEn, lsGateEn}, 16'h0000);
    $display("Test overvoltage in ramp");
    wr(`REG_TON_DELAY, 16'h0000);
    enablePin <= 1'b1;
    waitConv(1'b1, 8, n);
    repeat (5) @(negedge mclk);
    ovTrip <= 1'b1;
    waitConv(1'b0, 4, n);
    ovTrip <= 1'b0;
    repeat (3) @(negedge mclk);
    wr(`REG_CLEAR, 16'h0001);
    repeat (3) @(negedge mclk);
    check("alert released", {15'h0000, alertOut_n}, 16'h0001);
    $display("Test hiccup");
    waitConv(1'b1, 12, n);
    repeat (40) @(negedge mclk);
    overload <= 1'b1;
    waitConv(1'b0, 8 * PER + 10, n);
    waitConv(1'b1, 20 * MS + 40, n);
    check("hiccup length", {15'h0000, n >= 20 * MS - 4}, 16'h0001);
    waitConv(1'b0, 8 * PER + 10, n);
    overload <= 1'b0;
    waitConv(1'b1, 20 * MS + 40, n);
    $display("Test latched response");
    wr(`REG_CTRL, 16'h0020);
    overload <= 1'b1;
    waitConv(1'b0, 8 * PER + 10, n);
    overload <= 1'b0;
    repeat (25 * MS) @(negedge mclk);
    check("stays latched", {15'h0000, convEnable}, 16'h0000);
    wr(`REG_CTRL, 16'h0040);
    enablePin <= 1'b0;
    repeat (4) @(negedge mclk);
    enablePin <= 1'b1;
    $display("Test duty foldback");
    waitConv(1'b1, 12, n);
    repeat (40) @(negedge mclk);
    overload <= 1'b1;
    waitCap(CAP_HALF, 3 * PER + 10, n);
    check("fold run", {15'h0000, n >= 2 * PER}, 16'h0001);
    overload <= 1'b0;
    waitCap(CAP_NOM, 4 * PER + 12, n);
    check("recover run", {15'h0000, n >= 3 * PER}, 16'h0001);
    dutyBelowEighth <= 1'b1;
    overload <= 1'b1;
    repeat (5 * PER) @(negedge mclk);
    check("no foldback", {14'h0000, dutyCap}, {14'h0000, CAP_NOM});
    waitConv(1'b0, 4 * PER + 10, n);
    overload <= 1'b0;
    dutyBelowEighth <= 1'b0;
    $display("Test soft stop");
    wr(`REG_TOFF_DELAY, 16'h0001);
    wr(`REG_TOFF_FALL, 16'h0001);
    wr(`REG_CTRL, 16'h000b);
    waitConv(1'b1, 20 * MS + 40, n);
    repeat (60) @(negedge mclk);
    wr(`REG_CTRL, 16'h000a);
    repeat (MS - 4) @(negedge mclk);
    check("stop delay", {15'h0000, convEnable}, 16'h0001);
    waitConv(1'b0, 2 * MS + 10, n);
    stop_test();
  end
endmodule
